/* design/cia_irq_ack.sv */
`timescale 1ns/10ps
module cia_irq_ack
import cia_pkg::*;
#(
    parameter int N = NSRC,
    parameter logic [15:0] VEC_BASE = VEC_BASE_DEF,
    parameter logic [15:0] TRAP_VEC = TRAP_VEC_DEF
)
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [N-1:0] irq_req,
    input wire logic instr_boundary,
    input wire cia_op_t instr_op,
    input wire logic [7:0] instr_b1,
    input wire logic [7:0] instr_b2,
    input wire logic [7:0] instr_b3,
    input wire logic [7:0] instr_b4,
    input wire logic [15:0] instr_pc,
    input wire logic [15:0] resume_pc,
    input wire logic [7:0] status_pop,
    output logic act_valid,
    output cia_act_t act_kind,
    output logic [$clog2(N)-1:0] act_src,
    output logic [2:0] act_bank,
    output logic [15:0] act_vec,
    output logic [15:0] act_save_pc,
    output logic [15:0] act_imm
);
    localparam int IW = $clog2(N);

    logic [N-1:0] req;
    logic [N-1:0] mask;
    logic [N-1:0] ms_en;
    logic [N-1:0] cs_en;
    logic [2*N-1:0] prio;
    logic irq_en;
    logic nest;
    logic [3:0] insvc;
    logic bus_ack;
    logic [N-1:0] elig;
    logic [N-1:0] ms_cand;
    logic [N-1:0] vec_cand;
    logic [3:0] lvl_ok;
    logic ms_found;
    logic vec_found;
    logic [IW-1:0] ms_idx;
    logic [IW-1:0] vec_idx;
    logic [1:0] vec_lvl;
    logic [15:0] vaddr;
    logic [8*N-1:0] msc_all;
    logic [7:0] ms_cur;
    logic ms_done;
    logic [N-1:0] sw_clr;
    logic [N-1:0] hw_clr;
    logic [N-1:0] done_set;
    logic wr_go;
    logic bank_ret;
    logic [1:0] act_lvl;
    logic [N-1:0] elig_q;
    cia_act_t d_kind;
    logic [IW-1:0] d_src;
    logic [2:0] d_bank;
    logic [15:0] d_vec;
    logic [15:0] d_pc;
    logic [15:0] d_imm;
    logic taken_int;
    logic is_ret;

    // Eligibility: flag set and mask clear
    assign elig = req & ~mask; // [RQ1]
    assign ms_cand = elig & ms_en; // [RQ2]

    // Levels acceptable given enable, in-service bits and nest select
    always_comb
    begin
        if (!irq_en || insvc[0]) // [RQ14]
            lvl_ok = 4'h0;
        else if (insvc[1]) // [RQ16]
            lvl_ok = 4'h1;
        else if (insvc[2]) // [RQ16]
            lvl_ok = 4'h3;
        else if (insvc[3]) // [RQ15]
            lvl_ok = nest ? 4'h7 : 4'hF;
        else
            lvl_ok = 4'hF;
    end

    // Vectored and context candidates per source
    for (genvar g = 0; g < N; g++)
    begin : g_cand
        assign vec_cand[g] = elig[g] & ~ms_en[g]
            & lvl_ok[prio[2*g +: 2]]; // [RQ3] [RQ12]
    end

    cia_pick #(.N(N), .IW(IW)) u_pick_ms (
        .cand(ms_cand),
        .lvl('0),
        .found(ms_found),
        .idx(ms_idx)
    );

    cia_pick #(.N(N), .IW(IW)) u_pick_vec (
        .cand(vec_cand),
        .lvl(prio),
        .found(vec_found),
        .idx(vec_idx)
    );

    assign vec_lvl = prio[2*vec_idx +: 2];
    assign vaddr = VEC_BASE + {{(15-IW){1'b0}}, vec_idx, 1'b0};
    assign ms_cur = msc_all[8*ms_idx +: 8];
    assign bank_ret = instr_b1 == BRET_OP1 && instr_b2 == BRET_OP2;

    // Next action, decided only at an instruction boundary
    always_comb
    begin
        d_kind = ACT_NONE;
        d_src = '0;
        d_bank = 3'h0;
        d_vec = 16'h0000;
        d_pc = resume_pc;
        d_imm = 16'h0000;
        if (instr_boundary) // [RQ26]
        begin
            case (instr_op)
                OP_STK_BREAK:
                begin
                    d_kind = ACT_STK_BREAK;
                    d_vec = BREAK_VEC; // [RQ17]
                end
                OP_BANK_BREAK:
                begin
                    d_kind = ACT_BANK_BREAK;
                    d_bank = instr_b2[2:0]; // [RQ18]
                end
                OP_VEC_RET: d_kind = ACT_VEC_RET;
                OP_STK_RET: d_kind = ACT_STK_RET;
                OP_CTX_RET:
                begin
                    if (bank_ret) // [RQ19]
                    begin
                        d_kind = ACT_BANK_RET;
                        d_imm = {instr_b4, instr_b3};
                    end
                    else
                    begin
                        d_kind = ACT_CTX_RET;
                        d_imm = {instr_b3, instr_b2}; // [RQ10]
                    end
                end
                OP_MOV_SPC:
                begin
                    if (~instr_b3 != instr_b4) // [RQ20]
                    begin
                        d_kind = ACT_TRAP;
                        d_vec = TRAP_VEC;
                        d_pc = instr_pc; // [RQ21]
                    end
                end
                default: d_kind = ACT_NONE;
            endcase
            if (d_kind == ACT_NONE)
            begin
                if (ms_found) // [RQ2]
                begin
                    d_kind = ACT_MACRO;
                    d_src = ms_idx;
                end
                else if (vec_found) // [RQ3] [RQ5]
                begin
                    d_src = vec_idx;
                    d_vec = vaddr;
                    if (cs_en[vec_idx]) // [RQ7]
                    begin
                        d_kind = ACT_CTX; // [RQ9]
                        d_bank = vaddr[2:0]; // [RQ8]
                    end
                    else
                        d_kind = ACT_VEC; // [RQ6]
                end
            end
        end
    end

    assign taken_int = d_kind == ACT_VEC || d_kind == ACT_CTX;
    assign is_ret = d_kind == ACT_VEC_RET || d_kind == ACT_STK_RET
        || d_kind == ACT_CTX_RET || d_kind == ACT_BANK_RET;
    assign ms_done = d_kind == ACT_MACRO && ms_cur <= 8'h01;

    // Action to the sequencer, one cycle after the boundary
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            act_valid <= 1'b0;
            act_kind <= ACT_NONE;
            act_src <= '0;
            act_bank <= 3'h0;
            act_vec <= 16'h0000;
            act_save_pc <= 16'h0000;
            act_imm <= 16'h0000;
            act_lvl <= 2'h0;
        end
        else
        begin
            act_valid <= d_kind != ACT_NONE;
            act_kind <= d_kind;
            act_src <= d_src;
            act_bank <= d_bank;
            act_vec <= d_vec;
            act_save_pc <= d_pc;
            act_imm <= d_imm;
            act_lvl <= vec_lvl;
        end
    end

    // Global enable: hardware events win over a register write
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            irq_en <= 1'b0;
        else if (taken_int || d_kind == ACT_STK_BREAK
            || d_kind == ACT_BANK_BREAK || d_kind == ACT_TRAP)
            irq_en <= 1'b0; // [RQ13] [RQ6] [RQ17] [RQ21]
        else if (is_ret)
            irq_en <= status_pop[STATUS_GIE_BIT];
        else if (instr_boundary && instr_op == OP_IRQ_ON)
            irq_en <= 1'b1;
        else if (instr_boundary && instr_op == OP_IRQ_OFF)
            irq_en <= 1'b0;
        else if (wr_go && avs_address == OFF_CTRL)
            irq_en <= avs_writedata[CTRL_GIE_BIT];
    end

    // Nest select, software owned
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            nest <= RST_NEST; // [RQ25]
        else if (wr_go && avs_address == OFF_CTRL)
            nest <= avs_writedata[CTRL_NEST_BIT];
    end

    // In-service level bits
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            insvc <= 4'h0;
        else if (taken_int)
            insvc <= insvc | (4'h1 << vec_lvl); // [RQ6]
        else if (d_kind == ACT_VEC_RET || d_kind == ACT_CTX_RET) // [RQ24]
            insvc <= insvc & (insvc - 4'h1); // [RQ11] [RQ23]
    end

    // Request flags: sets win over every clear
    assign sw_clr = (wr_go && avs_address == OFF_REQ)
        ? avs_writedata[N-1:0] : '0;
    assign hw_clr = (taken_int || d_kind == ACT_MACRO)
        ? ({{(N-1){1'b0}}, 1'b1} << d_src) : '0;
    assign done_set = ms_done ? ({{(N-1){1'b0}}, 1'b1} << d_src) : '0;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            req <= '0;
        else
            req <= (req & ~sw_clr & ~hw_clr) | irq_req | done_set; // [RQ5]
    end

    // Macro enables: a finished channel turns into a vectored request
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            ms_en <= '0;
        else if (ms_done)
            ms_en <= ms_en & ~done_set; // [RQ22]
        else if (wr_go && avs_address == OFF_MSEN)
            ms_en <= avs_writedata[N-1:0];
    end

    // Mask, level fields and context enables
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            mask <= RST_MASK[N-1:0];
            prio <= RST_PRIO[2*N-1:0];
            cs_en <= '0;
        end
        else if (wr_go)
        begin
            if (avs_address == OFF_MASK)
                mask <= avs_writedata[N-1:0];
            else if (avs_address == OFF_PRIO)
                prio <= avs_writedata[2*N-1:0]; // [RQ12]
            else if (avs_address == OFF_CSEN)
                cs_en <= avs_writedata[N-1:0];
        end
    end

    // Transfer counters, one per channel
    for (genvar g = 0; g < N; g++)
    begin : g_msc
        logic [7:0] cnt;
        always_ff @(posedge clk_sys)
        begin
            if (sys_rst)
                cnt <= 8'h00;
            else if (wr_go && avs_address == OFF_MSC + 8'(4*g))
                cnt <= avs_writedata[7:0];
            else if (d_kind == ACT_MACRO && d_src == IW'(g)
                && cnt != 8'h00)
                cnt <= cnt - 8'h01; // [RQ22]
        end
        assign msc_all[8*g +: 8] = cnt;
    end

    // Bus slave: every access answers at its second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~bus_ack;
    assign wr_go = avs_write & bus_ack;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            bus_ack <= 1'b0;
        else
            bus_ack <= (avs_read | avs_write) & ~bus_ack;
    end

    // Read data, unmapped offsets read zero
    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read && !bus_ack)
        begin
            if (avs_address == OFF_CTRL)
                avs_readdata <= {24'h000000, nest, 6'h00, irq_en};
            else if (avs_address == OFF_INSVC)
                avs_readdata <= {28'h0000000, insvc};
            else if (avs_address == OFF_REQ)
                avs_readdata <= 32'(req);
            else if (avs_address == OFF_MASK)
                avs_readdata <= 32'(mask);
            else if (avs_address == OFF_PRIO)
                avs_readdata <= 32'(prio);
            else if (avs_address == OFF_MSEN)
                avs_readdata <= 32'(ms_en);
            else if (avs_address == OFF_CSEN)
                avs_readdata <= 32'(cs_en);
            else if (avs_address[7:6] == 2'b01
                && avs_address[1:0] == 2'b00
                && 32'(avs_address[5:2]) < N)
                avs_readdata <= {24'h000000,
                    msc_all[8*avs_address[5:2] +: 8]};
            else
                avs_readdata <= 32'h00000000;
        end
    end

    // Checks
    always_ff @(posedge clk_sys)
    begin
        elig_q <= elig;
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    a_mask_gate: assert property ( // [RQ1]
        act_valid && act_kind inside {ACT_VEC, ACT_CTX, ACT_MACRO}
        |-> elig_q[act_src])
        else $error("Masked or unflagged request taken");
    a_enable_gate: assert property ( // [RQ3]
        act_valid && act_kind inside {ACT_VEC, ACT_CTX} |-> $past(irq_en))
        else $error("Interrupt taken with enable clear");
    a_ack_disables: assert property ( // [RQ13]
        act_valid && act_kind inside {ACT_VEC, ACT_CTX, ACT_STK_BREAK,
        ACT_BANK_BREAK, ACT_TRAP} |-> !irq_en)
        else $error("Enable not cleared on acknowledge");
    a_macro_keeps_en: assert property ( // [RQ2]
        act_valid && act_kind == ACT_MACRO && !$past(wr_go)
        |-> irq_en == $past(irq_en))
        else $error("Macro service changed enable");
    a_level_marked: assert property ( // [RQ6]
        act_valid && act_kind == ACT_VEC |-> insvc[act_lvl])
        else $error("In-service bit not set");
    a_return_clears: assert property ( // [RQ11]
        act_valid && act_kind inside {ACT_VEC_RET, ACT_CTX_RET}
        |-> insvc == ($past(insvc) & ($past(insvc) - 4'h1)))
        else $error("Wrong in-service bit cleared");
    a_break_ret_keeps: assert property ( // [RQ24]
        act_valid && act_kind inside {ACT_STK_RET, ACT_BANK_RET}
        |-> $stable(insvc))
        else $error("Break return touched in-service bits");
    a_break_vector: assert property ( // [RQ17]
        act_valid && act_kind == ACT_STK_BREAK |-> act_vec == BREAK_VEC)
        else $error("Stack break vector wrong");
    a_nest_block: assert property ( // [RQ15]
        act_valid && act_kind inside {ACT_VEC, ACT_CTX}
        && $past(insvc) == 4'h8 && $past(nest) |-> act_lvl != 2'h3)
        else $error("Level 3 nested with nest select set");
    a_trap_cause: assert property ( // [RQ20]
        act_valid && act_kind == ACT_TRAP
        |-> (~$past(instr_b3)) != $past(instr_b4))
        else $error("Trap without operand mismatch");
    a_boundary_only: assert property ( // [RQ26]
        act_valid |-> $past(instr_boundary))
        else $error("Action outside instruction boundary");

    c_macro: cover property (act_valid && act_kind == ACT_MACRO);
    c_nested: cover property (act_valid && act_kind == ACT_VEC
        && $past(insvc) != 4'h0);
    c_ctx_ret: cover property (act_valid && act_kind == ACT_CTX_RET);
    c_trap: cover property (act_valid && act_kind == ACT_TRAP);
endmodule // cia_irq_ack

/* design/cia_pkg.sv */
// Notes on behaviour
// [RQ1] A request is eligible only with its flag set and its mask clear.
// [RQ2] Eligible macro-service requests are taken at once, ignoring the enable flag.
// [RQ3] Vectored or context requests need enable set and an acceptable level.
// [RQ4] Simultaneous requests go by programmed level, then fixed default order.
// [RQ5] A request not yet taken stays pending until conditions allow it.
// [RQ6] Vectored take: push status and pc, clear enable, mark level, load vector.
// [RQ7] Context switching is used only when the source's switch enable is set.
// [RQ8] Context bank is the low three bits of the source's even vector address.
// [RQ9] Context take loads pc from bank and saves pc and status there.
// [RQ10] Context return restores pc and status, writes immediate bytes 2,3 to pair 4/5.
// [RQ11] Context return clears the highest-priority in-service bit.
// [RQ12] Each request has a two-bit field placing it in one of four levels.
// [RQ13] Any acknowledge clears the enable flag; nesting needs software to set it. A macro-service take leaves it unchanged.
// [RQ14] Enable clear or level 0 in service: only macro service accepted.
// [RQ15] Level 3 in service: level 3 accepted only with nest select clear.
// [RQ16] Level 2 in service allows levels 0,1; level 1 allows level 0.
// [RQ17] Stack break always taken: push, clear enable, vector from 003EH.
// [RQ18] Bank break uses bank from second byte, branches, saves pc and status.
// [RQ19] Bank-break return is 09H E0H; restores, writes bytes 3,4 to pair 4/5.
// [RQ20] Special-register immediate move traps when inverted byte 3 differs byte 4.
// [RQ21] Trap pushes status and instruction start, clears enable, takes trap vector.
// [RQ22] Macro service raises a vectored request after its programmed transfer count.
// [RQ23] Vectored return clears the highest-priority in-service bit.
// [RQ24] Stack-break and bank-break returns leave in-service bits unchanged.
// [RQ25] Reset sets the level-3 nest select flag.
// [RQ26] Requests are evaluated and taken only at instruction boundaries.
package cia_pkg;
    localparam int NSRC = 16;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSVC = 8'h04;
    localparam logic [7:0] OFF_REQ = 8'h08;
    localparam logic [7:0] OFF_MASK = 8'h0C;
    localparam logic [7:0] OFF_PRIO = 8'h10;
    localparam logic [7:0] OFF_MSEN = 8'h14;
    localparam logic [7:0] OFF_CSEN = 8'h18;
    localparam logic [7:0] OFF_MSC = 8'h40;
    // Field positions and reset values
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_NEST_BIT = 7;
    localparam int STATUS_GIE_BIT = 1;
    localparam logic RST_NEST = 1'b1;
    localparam logic [15:0] RST_MASK = 16'hFFFF;
    localparam logic [31:0] RST_PRIO = 32'hFFFFFFFF;
    // Vector addresses and op-code bytes
    localparam logic [15:0] BREAK_VEC = 16'h003E;
    localparam logic [15:0] TRAP_VEC_DEF = 16'h003C;
    localparam logic [15:0] VEC_BASE_DEF = 16'h0040;
    localparam logic [7:0] BRET_OP1 = 8'h09;
    localparam logic [7:0] BRET_OP2 = 8'hE0;
    typedef enum logic [3:0] {
        OP_NONE, OP_STK_BREAK, OP_BANK_BREAK, OP_VEC_RET, OP_STK_RET,
        OP_CTX_RET, OP_IRQ_ON, OP_IRQ_OFF, OP_MOV_SPC
    } cia_op_t;
    typedef enum logic [3:0] {
        ACT_NONE, ACT_VEC, ACT_CTX, ACT_MACRO, ACT_STK_BREAK, ACT_BANK_BREAK,
        ACT_TRAP, ACT_VEC_RET, ACT_STK_RET, ACT_CTX_RET, ACT_BANK_RET
    } cia_act_t;
endpackage

/* design/cia_pick.sv */
`timescale 1ns/10ps
// Picks the lowest level, then the lowest index, among candidates
module cia_pick
#(
    parameter int N = 16,
    parameter int IW = 4
)
(
    input wire logic [N-1:0] cand,
    input wire logic [2*N-1:0] lvl,
    output logic found,
    output logic [IW-1:0] idx
);
    // Level sweep outside, default order inside
    always_comb
    begin
        found = 1'b0;
        idx = '0;
        for (int l = 0; l < 4; l++)
        begin
            for (int i = 0; i < N; i++)
            begin
                if (!found && cand[i] && lvl[2*i +: 2] == l[1:0]) // [RQ4]
                begin
                    found = 1'b1;
                    idx = i[IW-1:0];
                end
            end
        end
    end
endmodule // cia_pick

/* tb/cia_seq_model.sv */
`timescale 1ns/10ps
// Stands in for the instruction sequencer and the request sources
module cia_seq_model
import cia_pkg::*;
(
    input wire logic clk_sys,
    input wire logic act_valid,
    input wire cia_act_t act_kind,
    input wire logic [3:0] act_src,
    input wire logic [2:0] act_bank,
    input wire logic [15:0] act_vec,
    input wire logic [15:0] act_save_pc,
    input wire logic [15:0] act_imm,
    output logic [15:0] irq_req,
    output logic instr_boundary,
    output cia_op_t instr_op,
    output logic [7:0] instr_b1,
    output logic [7:0] instr_b2,
    output logic [7:0] instr_b3,
    output logic [7:0] instr_b4,
    output logic [15:0] instr_pc,
    output logic [15:0] resume_pc,
    output logic [7:0] status_pop
);
    logic [63:0] last = 64'h0;
    int act_cnt = 0;

    // Quiet sequencer at time zero
    initial
    begin
        irq_req = 16'h0000;
        instr_boundary = 1'b0;
        instr_op = OP_NONE;
        {instr_b4, instr_b3, instr_b2, instr_b1} = 32'h0;
        instr_pc = 16'h0000;
        resume_pc = 16'h0000;
        status_pop = 8'h00;
    end

    // Records every action handed over, packed field by field
    always @(posedge clk_sys)
    begin
        if (act_valid === 1'b1)
        begin
            last <= {4'h0, act_kind, act_src, 1'b0, act_bank, act_vec,
                act_save_pc, act_imm};
            act_cnt <= act_cnt + 1;
        end
    end

    // Raises a set of peripheral requests for one cycle
    task automatic pulse(input logic [15:0] m);
        @(posedge clk_sys);
        irq_req <= m;
        @(posedge clk_sys);
        irq_req <= 16'h0000;
    endtask

    // One boundary; the op bytes go stale once it is taken
    task automatic step(input cia_op_t op, input logic [31:0] b,
        input logic [7:0] sp);
        @(posedge clk_sys);
        instr_boundary <= 1'b1;
        instr_op <= op;
        {instr_b4, instr_b3, instr_b2, instr_b1} <= b;
        instr_pc <= {8'h12, b[7:0]}; // Start follows the first op byte
        resume_pc <= {8'h12, b[7:0]} + 16'h0004;
        status_pop <= sp;
        @(posedge clk_sys);
        instr_boundary <= 1'b0;
        instr_op <= OP_NONE;
        {instr_b4, instr_b3, instr_b2, instr_b1} <= ~b;
        status_pop <= ~sp;
        repeat (2) @(posedge clk_sys);
    endtask
endmodule // cia_seq_model

/* tb/cia_irq_ack_tb_top.sv */
`timescale 1ns/10ps
module cia_irq_ack_tb_top
import cia_pkg::*;
;
    localparam logic [63:0] MK = 64'h0F00000000000000;
    localparam logic [63:0] MS = 64'h00F0000000000000;
    localparam logic [63:0] MB = 64'h000F000000000000;
    localparam logic [63:0] MV = 64'h0000FFFF00000000;
    localparam logic [63:0] MP = 64'h00000000FFFF0000;
    localparam logic [63:0] MI = 64'h000000000000FFFF;
    localparam logic [63:0] VM = MK | MS | MV | MP;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, instr_boundary, act_valid;
    logic [15:0] irq_req, instr_pc, resume_pc, act_vec, act_save_pc, act_imm;
    cia_op_t instr_op;
    cia_act_t act_kind;
    logic [7:0] instr_b1, instr_b2, instr_b3, instr_b4, status_pop;
    logic [3:0] act_src;
    logic [2:0] act_bank;
    int error_cnt = 0;
    int tests_run = 0;
    int ecnt = 0;
    logic [7:0] ra [8];
    logic [31:0] rv [8];

    // Free-running system clock
    always #20 clk_sys = ~clk_sys;

    cia_irq_ack u_dut (.clk_sys, .sys_rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
        .irq_req, .instr_boundary, .instr_op, .instr_b1, .instr_b2,
        .instr_b3, .instr_b4, .instr_pc, .resume_pc, .status_pop,
        .act_valid, .act_kind, .act_src, .act_bank, .act_vec,
        .act_save_pc, .act_imm);

    cia_seq_model u_seq (.clk_sys, .act_valid, .act_kind, .act_src,
        .act_bank, .act_vec, .act_save_pc, .act_imm, .irq_req,
        .instr_boundary, .instr_op, .instr_b1, .instr_b2, .instr_b3,
        .instr_b4, .instr_pc, .resume_pc, .status_pop);

    task automatic summarize();
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One register access; held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0)
        begin
            error_cnt++;
            summarize();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk({32'h0, q}, {32'h0, e});
    endtask

    function automatic logic [63:0] pk(cia_act_t k, logic [3:0] s,
        logic [2:0] bk, logic [15:0] v, logic [15:0] pc, logic [15:0] im);
        return {4'h0, k, s, 1'b0, bk, v, pc, im};
    endfunction

    // One boundary; mask m of zero means no action is expected
    task automatic st(input cia_op_t op, input logic [31:0] b,
        input logic [7:0] sp, input logic [63:0] e, input logic [63:0] m);
        u_seq.step(op, b, sp);
        if (m != 64'h0)
            ecnt++;
        chk(u_seq.act_cnt, ecnt);
        if (m != 64'h0)
            chk(u_seq.last & m, e & m);
    endtask

    task automatic sv(input logic [3:0] s);
        st(OP_NONE, 0, 0, pk(ACT_VEC, s, 0, VEC_BASE_DEF + 2 * s,
            16'h1204, 0), VM);
    endtask

    task automatic sn();
        st(OP_NONE, 0, 0, 0, 0);
    endtask

    // Main sequence
    initial
    begin
        ra = '{OFF_CTRL, OFF_INSVC, OFF_REQ, OFF_MASK, OFF_PRIO, OFF_MSEN,
            OFF_CSEN, 8'h20};
        rv = '{32'h80, 0, 0, 32'hFFFF, 32'hFFFFFFFF, 0, 0, 0};
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++)
            rdc(ra[i], rv[i]);
        // Masked request waits, then enable gating
        u_seq.pulse(16'h0008);
        sn();
        rdc(OFF_REQ, 32'h8);
        wr(OFF_MASK, 32'hFFF7);
        sn();
        wr(OFF_CTRL, 32'h81);
        repeat (5) @(posedge clk_sys);
        chk(u_seq.act_cnt, ecnt);
        sv(3);
        rdc(OFF_CTRL, 32'h80);
        rdc(OFF_INSVC, 32'h08);
        rdc(OFF_REQ, 32'h0);
        // Level-3 nesting under the select flag
        wr(OFF_MASK, 32'hFFD7);
        wr(OFF_CTRL, 32'h81);
        u_seq.pulse(16'h0020);
        sn();
        wr(OFF_CTRL, 32'h01);
        sv(5);
        st(OP_VEC_RET, 0, 0, pk(ACT_VEC_RET, 0, 0, 0, 0, 0), MK);
        rdc(OFF_INSVC, 32'h0);
        // Programmed levels and default order
        wr(OFF_PRIO, 32'hFCF3FFDF);
        wr(OFF_MASK, 32'hEDEB);
        wr(OFF_CTRL, 32'h81);
        u_seq.pulse(16'h1204);
        sv(9);
        rdc(OFF_INSVC, 32'h01);
        wr(OFF_CTRL, 32'h81);
        sn();
        st(OP_VEC_RET, 0, 8'h02, pk(ACT_VEC_RET, 0, 0, 0, 0, 0), MK);
        sv(12);
        st(OP_VEC_RET, 0, 8'h02, pk(ACT_VEC_RET, 0, 0, 0, 0, 0), MK);
        sv(2);
        rdc(OFF_INSVC, 32'h02);
        wr(OFF_CTRL, 32'h81);
        u_seq.pulse(16'h0010);
        sn();
        st(OP_CTX_RET, 32'h001234AA, 8'h02,
            pk(ACT_CTX_RET, 0, 0, 0, 0, 16'h1234), MK | MI);
        rdc(OFF_INSVC, 32'h0);
        sv(4);
        st(OP_VEC_RET, 0, 0, pk(ACT_VEC_RET, 0, 0, 0, 0, 0), MK);
        // Context switching for one source
        wr(OFF_CSEN, 32'h40);
        wr(OFF_MASK, 32'hFFBF);
        wr(OFF_CTRL, 32'h81);
        u_seq.pulse(16'h0040);
        st(OP_NONE, 0, 0, pk(ACT_CTX, 6, 4, 16'h004C, 16'h1204, 0),
            VM | MB);
        st(OP_CTX_RET, 32'h5678E009, 0,
            pk(ACT_BANK_RET, 0, 0, 0, 0, 16'h5678), MK | MI);
        rdc(OFF_INSVC, 32'h08);
        // Macro service with the enable flag clear
        wr(OFF_MSEN, 32'h80);
        wr(OFF_MSC + 8'h1C, 32'h2);
        wr(OFF_MASK, 32'hFF7F);
        wr(OFF_CTRL, 32'h80);
        u_seq.pulse(16'h0080);
        st(OP_NONE, 0, 0, pk(ACT_MACRO, 7, 0, 0, 0, 0), MK | MS);
        u_seq.pulse(16'h0080);
        st(OP_NONE, 0, 0, pk(ACT_MACRO, 7, 0, 0, 0, 0), MK | MS);
        rdc(OFF_REQ, 32'h80);
        wr(OFF_CTRL, 32'h01);
        sv(7);
        // Software breaks, returns and the op-code trap
        wr(OFF_CTRL, 32'h01);
        st(OP_STK_BREAK, 0, 0, pk(ACT_STK_BREAK, 0, 0, BREAK_VEC, 16'h1204, 0),
            MK | MV | MP);
        rdc(OFF_CTRL, 32'h00);
        st(OP_BANK_BREAK, 32'h0000FD00, 0,
            pk(ACT_BANK_BREAK, 0, 5, 0, 16'h1204, 0), MK | MB | MP);
        st(OP_STK_RET, 0, 0, pk(ACT_STK_RET, 0, 0, 0, 0, 0), MK);
        rdc(OFF_INSVC, 32'h08);
        st(OP_MOV_SPC, 32'hA55A0000, 0, 0, 0);
        st(OP_MOV_SPC, 32'hA45A0010, 0,
            pk(ACT_TRAP, 0, 0, TRAP_VEC_DEF, 16'h1210, 0),
            MK | MV | MP);
        summarize();
    end
endmodule // cia_irq_ack_tb_top
